/* rtl/chan_cfg_pkg.sv */
// Constants shared by the channel configuration register bank
package chan_cfg_pkg;

  // ---------------------------------------------------------------
  // External port locations
  // ---------------------------------------------------------------
  localparam logic [2:0] EXT_PAGE = 3'h7;
  localparam logic [2:0] EXT_IADDR = 3'h6;
  localparam logic [2:0] EXT_BYTE3 = 3'h3;
  localparam logic [2:0] EXT_BYTE2 = 3'h2;
  localparam logic [2:0] EXT_BYTE1 = 3'h1;
  localparam logic [2:0] EXT_BYTE0 = 3'h0;

  // ---------------------------------------------------------------
  // Channel pages and internal offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] PAGE_FIRST = 8'h01;
  localparam logic [7:0] OFS_TAP_COUNT = 8'h0a;
  localparam logic [7:0] OFS_COEF_OFFSET = 8'h0b;
  localparam logic [7:0] OFS_MODE_ONE = 8'h0c;
  localparam logic [7:0] OFS_MODE_TWO = 8'h0d;
  localparam logic [7:0] OFS_RSVD_ZERO_A = 8'h10;
  localparam logic [7:0] OFS_RSVD_ZERO_B = 8'h11;
  localparam logic [2:0] SAMPLE_WIN_TAG = 3'h1;
  localparam logic [4:0] SAMPLE_WORDS_M1 = 5'h1f;

  // ---------------------------------------------------------------
  // Field layouts and reset values
  // ---------------------------------------------------------------
  localparam int RATIO_LSB = 0;
  localparam int FORMAT_LSB = 4;
  localparam int SCLK_DIV_LSB = 0;
  localparam int MODE2_RSVD_BIT = 5;
  localparam int COARSE_LSB = 6;
  localparam logic [1:0] FORMAT_FIR = 2'h0;
  localparam logic [6:0] TAP_COUNT_MAX_M1 = 7'h7f;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [6:0] RESET_TAPS = 7'h00;
  localparam logic [4:0] RESET_DIV = 5'h00;

endpackage

/* rtl/channel_regs.sv */
// One channel's configuration registers, memories and serial clock
`timescale 1ns/10ps
`default_nettype none
module channel_regs
  import chan_cfg_pkg::*;
#(
  parameter int SAMPLE_DEPTH = 32,
  parameter int COEF_DEPTH = 128
) (
  // Clock and control
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // Internal access
  input wire logic wr_en,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  output logic [31:0] rdata,
  // Filter coefficient fetch
  input wire logic [6:0] tap_idx,
  output logic [15:0] coef_out,
  // Configuration to datapath
  output logic [7:0] coef_offset,
  output logic [6:0] tap_count_m1,
  output logic [3:0] tap_ratio_m1,
  output logic [1:0] input_format,
  output logic [4:0] sclk_divider,
  output logic [1:0] coarse_scale,
  output logic sclk_out
);

  logic [15:0] sample_store [SAMPLE_DEPTH];
  logic [15:0] coef_store [COEF_DEPTH];
  logic [7:0] next_coef_offset;
  logic [6:0] next_tap_count_m1;
  logic [3:0] next_tap_ratio_m1;
  logic [1:0] next_input_format;
  logic [4:0] next_sclk_divider;
  logic [1:0] next_coarse_scale;
  logic [4:0] sclk_cnt;
  logic [4:0] next_sclk_cnt;
  logic next_sclk_out;
  logic [15:0] next_coef_out;
  logic sample_hit;
  logic coef_hit;

  assign sample_hit = (addr[7:5] == SAMPLE_WIN_TAG);
  assign coef_hit = addr[7];

  // ---------------------------------------------------------------
  // Register updates
  // ---------------------------------------------------------------
  always_comb begin
    next_coef_offset = coef_offset;
    next_tap_count_m1 = tap_count_m1;
    next_tap_ratio_m1 = tap_ratio_m1;
    next_input_format = input_format;
    next_sclk_divider = sclk_divider;
    next_coarse_scale = coarse_scale;
    if (wr_en) begin
      unique case (addr)
        // [R16] Clamp tap count
        OFS_TAP_COUNT: begin
          next_tap_count_m1 = wdata[7] ? TAP_COUNT_MAX_M1 : wdata[6:0];
        end
        // [R1] Store coefficient base
        OFS_COEF_OFFSET: begin
          next_coef_offset = wdata[7:0];
        end
        OFS_MODE_ONE: begin
          // [R2] Tap ratio field
          next_tap_ratio_m1 = wdata[RATIO_LSB +: 4];
          // [R3] Only FIR format kept
          next_input_format = FORMAT_FIR;
        end
        OFS_MODE_TWO: begin
          // [R4] Serial divider field
          next_sclk_divider = wdata[SCLK_DIV_LSB +: 5];
          // [R6] Coarse attenuation select
          next_coarse_scale = wdata[COARSE_LSB +: 2];
        end
        // [R18] Reserved locations ignored
        default: begin
        end
      endcase
    end
  end

  // [R4] Serial clock, period twice (divider plus one)
  always_comb begin
    next_sclk_cnt = sclk_cnt + 5'h01;
    next_sclk_out = sclk_out;
    if (sclk_cnt >= sclk_divider) begin
      next_sclk_cnt = 5'h00;
      next_sclk_out = ~sclk_out;
    end
  end

  // [R1] Coefficient fetch relative to base
  always_comb begin
    next_coef_out = coef_store[7'(coef_offset[6:0] + tap_idx)];
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      coef_offset <= RESET_BYTE;
      tap_count_m1 <= RESET_TAPS;
      tap_ratio_m1 <= 4'h0;
      input_format <= FORMAT_FIR;
      sclk_divider <= RESET_DIV;
      coarse_scale <= 2'h0;
      sclk_cnt <= RESET_DIV;
      sclk_out <= 1'b0;
      coef_out <= 16'h0000;
    end else if (ce) begin
      coef_offset <= next_coef_offset;
      tap_count_m1 <= next_tap_count_m1;
      tap_ratio_m1 <= next_tap_ratio_m1;
      input_format <= next_input_format;
      sclk_divider <= next_sclk_divider;
      coarse_scale <= next_coarse_scale;
      sclk_cnt <= next_sclk_cnt;
      sclk_out <= next_sclk_out;
      coef_out <= next_coef_out;
    end
  end

  // ---------------------------------------------------------------
  // Memory windows
  // ---------------------------------------------------------------
  // [R8] [R9] Host writes into memories
  always_ff @(posedge mclk) begin
    if (ce && wr_en && sample_hit) begin
      sample_store[addr[4:0]] <= wdata[15:0];
    end
    if (ce && wr_en && coef_hit) begin
      coef_store[addr[6:0]] <= wdata[15:0];
    end
  end

  always_comb begin
    rdata = 32'h0000_0000;
    if (coef_hit) begin
      rdata = {16'h0000, coef_store[addr[6:0]]};
    end else if (sample_hit) begin
      rdata = {16'h0000, sample_store[addr[4:0]]};
    end else begin
      unique case (addr)
        OFS_TAP_COUNT: rdata = {25'h0, tap_count_m1};
        OFS_COEF_OFFSET: rdata = {24'h0, coef_offset};
        OFS_MODE_ONE: rdata = {26'h0, input_format, tap_ratio_m1};
        OFS_MODE_TWO: rdata = {24'h0, coarse_scale, 1'b0, sclk_divider};
        default: rdata = 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // [R4] Serial clock holds between terminal counts
  sclk_hold_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R4]
    ce && (sclk_cnt < sclk_divider) |=> $stable(sclk_out))
    else $error("serial clock toggled early");
  // [R4] Serial clock flips at terminal count
  sclk_flip_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R4]
    ce && (sclk_cnt == sclk_divider) |=> sclk_out != $past(sclk_out))
    else $error("serial clock missed toggle");
  // [R18] Reserved zero locations leave settings alone
  reserved_write_a: assert property (@(posedge mclk) // [R18]
    disable iff (!rst_n)
    ce && wr_en && (addr == OFS_RSVD_ZERO_A || addr == OFS_RSVD_ZERO_B)
    |=> $stable(sclk_divider) && $stable(coarse_scale)
        && $stable(coef_offset) && $stable(tap_ratio_m1)
        && $stable(tap_count_m1))
    else $error("reserved write changed settings");
  // [R1] Coefficient output follows base plus index
  coef_base_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R1]
    ce && !wr_en |=> coef_out ===
      coef_store[7'($past(coef_offset[6:0]) + $past(tap_idx))])
    else $error("coefficient fetch ignored base");

endmodule
`default_nettype wire

/* rtl/transmit_channel_config_regs.sv */
// Byte-wide indirect host port over four channel register banks
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// [R1] Coefficient base pointer offsets filter fetches
// [R2] Mode one low nibble: tap ratio minus one
// [R3] Input format only FIR; others never programmed
// [R4] Divider sets serial clock period 2(div+1)
// [R5] Host writes mode two bit five zero
// [R6] Mode two top bits pick coarse attenuation
// [R7] Host writes zero to reserved pair
// [R8] Window 0x20 maps onto sample memory
// [R9] Window 0x80 maps onto coefficient memory
// [R10] Locations 7 page, 6 address, 3-0 data
// [R11] Writing byte zero commits assembled value
// [R12] Reading byte zero captures whole register
// [R13] Deinterleaved channels programmed identically by host
// [R14] Host staggers phase offsets by quarter range
// [R15] Host staggers start hold-off values
// [R16] Tap count limited to 128 coefficients
// [R17] Hold-off starts channels in succession; no hold-off logic here, writes to offset 0x00 are ignored
// [R18] Reserved location writes have no effect
module transmit_channel_config_regs
  import chan_cfg_pkg::*;
#(
  parameter int CHANNELS = 4
) (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic ce,
  // Host byte port
  input wire logic [2:0] ext_addr,
  input wire logic [7:0] host_wdata,
  input wire logic host_wr,
  input wire logic host_rd,
  output logic [7:0] host_rdata,
  // Datapath coefficient fetch
  input wire logic [6:0] tap_idx,
  output logic [CHANNELS-1:0][15:0] coef_out,
  // Per channel configuration
  output logic [CHANNELS-1:0][7:0] coef_offset,
  output logic [CHANNELS-1:0][6:0] tap_count_m1,
  output logic [CHANNELS-1:0][3:0] tap_ratio_m1,
  output logic [CHANNELS-1:0][1:0] input_format,
  output logic [CHANNELS-1:0][4:0] sclk_divider,
  output logic [CHANNELS-1:0][1:0] coarse_scale,
  output logic [CHANNELS-1:0] sclk_out
);

  logic rst_meta;
  logic rst_n;
  logic [7:0] page;
  logic [7:0] next_page;
  logic [7:0] iaddr;
  logic [7:0] next_iaddr;
  logic [31:0] iface;
  logic [31:0] next_iface;
  logic [7:0] next_host_rdata;
  logic [CHANNELS-1:0][31:0] ch_rdata;
  logic [CHANNELS-1:0] ch_wr;
  logic [31:0] sel_rdata;
  logic commit;

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ---------------------------------------------------------------
  // Channel selection
  // ---------------------------------------------------------------
  // [R11] Byte zero write commits to selected channel
  assign commit = host_wr && (ext_addr == EXT_BYTE0);

  always_comb begin
    ch_wr = '0;
    sel_rdata = 32'h0000_0000;
    for (int i = 0; i < CHANNELS; i++) begin
      if (page == 8'(PAGE_FIRST + 8'(i))) begin
        ch_wr[i] = commit;
        sel_rdata = ch_rdata[i];
      end
    end
  end

  // ---------------------------------------------------------------
  // Host interface registers
  // ---------------------------------------------------------------
  always_comb begin
    next_page = page;
    next_iaddr = iaddr;
    next_iface = iface;
    next_host_rdata = host_rdata;
    if (host_wr) begin
      unique case (ext_addr)
        // [R10] Page and address selection
        EXT_PAGE: next_page = host_wdata;
        EXT_IADDR: next_iaddr = host_wdata;
        // [R11] Upper bytes gathered first
        EXT_BYTE3: next_iface[31:24] = host_wdata;
        EXT_BYTE2: next_iface[23:16] = host_wdata;
        EXT_BYTE1: next_iface[15:8] = host_wdata;
        EXT_BYTE0: next_iface[7:0] = host_wdata;
        default: begin
        end
      endcase
    end else if (host_rd) begin
      unique case (ext_addr)
        // [R12] Byte zero read snapshots the register
        EXT_BYTE0: begin
          next_iface = sel_rdata;
          next_host_rdata = sel_rdata[7:0];
        end
        EXT_BYTE1: next_host_rdata = iface[15:8];
        EXT_BYTE2: next_host_rdata = iface[23:16];
        EXT_BYTE3: next_host_rdata = iface[31:24];
        EXT_PAGE: next_host_rdata = page;
        EXT_IADDR: next_host_rdata = iaddr;
        default: next_host_rdata = RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      page <= RESET_BYTE;
      iaddr <= RESET_BYTE;
      iface <= 32'h0000_0000;
      host_rdata <= RESET_BYTE;
    end else if (ce) begin
      page <= next_page;
      iaddr <= next_iaddr;
      iface <= next_iface;
      host_rdata <= next_host_rdata;
    end
  end

  // ---------------------------------------------------------------
  // Channel banks
  // ---------------------------------------------------------------
  for (genvar g = 0; g < CHANNELS; g++) begin : g_chan
    channel_regs u_chan (
      .mclk(mclk),
      .rst_n(rst_n),
      .ce(ce),
      .wr_en(ch_wr[g]),
      .addr(iaddr),
      .wdata({iface[31:8], host_wdata}),
      .rdata(ch_rdata[g]),
      .tap_idx(tap_idx),
      .coef_out(coef_out[g]),
      .coef_offset(coef_offset[g]),
      .tap_count_m1(tap_count_m1[g]),
      .tap_ratio_m1(tap_ratio_m1[g]),
      .input_format(input_format[g]),
      .sclk_divider(sclk_divider[g]),
      .coarse_scale(coarse_scale[g]),
      .sclk_out(sclk_out[g])
    );
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence first_chan_commit(logic [7:0] ofs);
    ce && commit && page == PAGE_FIRST && iaddr == ofs;
  endsequence

  sequence byte0_capture;
    ce && host_rd && !host_wr && ext_addr == EXT_BYTE0;
  endsequence

  page_select_a: assert property ( // [R10]
    ce && host_wr && ext_addr == EXT_PAGE |=> page == $past(host_wdata))
    else $error("page not taken");
  offset_commit_a: assert property ( // [R11]
    first_chan_commit(OFS_COEF_OFFSET)
    |=> coef_offset[0] == $past(host_wdata))
    else $error("byte zero write not committed");
  divider_commit_a: assert property ( // [R4]
    first_chan_commit(OFS_MODE_TWO)
    |=> sclk_divider[0] == $past(host_wdata[4:0])
        && coarse_scale[0] == $past(host_wdata[7:6]))
    else $error("mode two fields wrong");
  tap_limit_a: assert property ( // [R16]
    first_chan_commit(OFS_TAP_COUNT) ##0 host_wdata[7]
    |=> tap_count_m1[0] == TAP_COUNT_MAX_M1)
    else $error("tap count not limited");
  read_capture_a: assert property ( // [R12]
    byte0_capture |=> {iface[31:8], host_rdata} === $past(sel_rdata))
    else $error("byte zero read not captured");
  read_upper_a: assert property ( // [R12]
    ce && host_rd && !host_wr && ext_addr == EXT_BYTE1
    |=> host_rdata == $past(iface[15:8]))
    else $error("byte one read wrong");
  format_fir_a: assert property ( // [R3]
    input_format[0] == FORMAT_FIR && input_format[CHANNELS-1] == FORMAT_FIR)
    else $error("input format not FIR");
  ratio_commit_a: assert property ( // [R2]
    first_chan_commit(OFS_MODE_ONE)
    |=> tap_ratio_m1[0] == $past(host_wdata[3:0]))
    else $error("tap ratio not stored");

endmodule
`default_nettype wire

/* sim/host_port_model.sv */
// Host microprocessor model driving the byte-wide register port
`timescale 1ns/10ps
`default_nettype none
module host_port_model (
  // Clock
  input wire logic mclk,
  // Byte port
  output logic [2:0] ext_addr,
  output logic [7:0] host_wdata,
  output logic host_wr,
  output logic host_rd
);
  initial begin
    ext_addr = 3'h0;
    host_wdata = 8'h00;
    host_wr = 1'b0;
    host_rd = 1'b0;
  end

  // One write strobe; data line inverted once released
  task automatic put(input logic [2:0] a, input logic [7:0] d);
    @(negedge mclk);
    ext_addr = a;
    host_wdata = d;
    host_wr = 1'b1;
    @(negedge mclk);
    host_wr = 1'b0;
    host_wdata = ~d;
  endtask

  // One read strobe, then a quiet cycle
  task automatic get(input logic [2:0] a);
    @(negedge mclk);
    ext_addr = a;
    host_rd = 1'b1;
    @(negedge mclk);
    host_rd = 1'b0;
    @(negedge mclk);
  endtask

  // Page, address, upper bytes, byte zero last
  task automatic wr_reg(input logic [7:0] pg, input logic [7:0] ofs,
                        input logic [31:0] v, input int nb);
    put(3'h7, pg);
    put(3'h6, ofs);
    for (int i = nb - 1; i >= 0; i--) put(i[2:0], v[8*i +: 8]);
  endtask

  task automatic deint(input logic [7:0] mode_two);
    for (int c = 1; c <= 4; c++) begin
      wr_reg(c[7:0], 8'h0d, {24'h0, mode_two & 8'hdf}, 1);
      wr_reg(c[7:0], 8'h10, 32'h0, 2);
      wr_reg(c[7:0], 8'h11, 32'h0, 2);
      wr_reg(c[7:0], 8'h04, (c - 1) * 16384, 2);
      wr_reg(c[7:0], 8'h00, 1 + (c - 1) * 16, 1);
    end
  endtask
endmodule
`default_nettype wire

/* sim/tb.sv */
// Self-checking bench for the channel configuration register bank
`timescale 1ns/10ps
`default_nettype none
module tb;
  import chan_cfg_pkg::*;
  logic mclk, arst_n, ce;
  logic [2:0] ext_addr;
  logic [7:0] host_wdata, host_rdata;
  logic host_wr, host_rd;
  logic [6:0] tap_idx;
  logic [3:0][15:0] coef_out;
  logic [3:0][7:0] coef_offset, off_e;
  logic [3:0][6:0] tap_count_m1;
  logic [3:0][3:0] tap_ratio_m1;
  logic [3:0][1:0] input_format, coarse_scale;
  logic [3:0][4:0] sclk_divider;
  logic [3:0] sclk_out;
  logic [1:0] rd_pipe;
  logic [7:0] exp_q[$];
  logic [31:0] v, w;
  logic [6:0] k;
  int err_count, checks_done;

  transmit_channel_config_regs #(.CHANNELS(4))
    transmit_channel_config_regs_inst (
    .mclk(mclk), .arst_n(arst_n), .ce(ce), .ext_addr(ext_addr),
    .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd),
    .host_rdata(host_rdata), .tap_idx(tap_idx), .coef_out(coef_out),
    .coef_offset(coef_offset), .tap_count_m1(tap_count_m1),
    .tap_ratio_m1(tap_ratio_m1), .input_format(input_format),
    .sclk_divider(sclk_divider), .coarse_scale(coarse_scale),
    .sclk_out(sclk_out));
  host_port_model host_port_model_inst (.mclk(mclk), .ext_addr(ext_addr),
    .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd));

  always #2 mclk = ~mclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Read result monitor
  // ---------------------------------------------------------------
  always @(posedge mclk) begin
    if (rd_pipe[1]) begin
      if (exp_q.size() == 0) chk(32'h1, 32'h0);
      else chk(host_rdata, exp_q.pop_front());
    end
    if (!arst_n) rd_pipe <= 2'h0;
    else rd_pipe <= {rd_pipe[0], host_rd & ~host_wr & ce};
  end

  task automatic wr(input logic [7:0] p, o, input logic [31:0] d, input int n);
    host_port_model_inst.wr_reg(p, o, d, n);
    repeat (2) @(negedge mclk);
  endtask

  // Byte zero first, then the upper bytes
  task automatic rd_reg(input logic [7:0] p, o, input logic [31:0] e,
                        input int n);
    host_port_model_inst.put(3'h7, p);
    host_port_model_inst.put(3'h6, o);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back(e[8*i +: 8]);
      host_port_model_inst.get(i[2:0]);
    end
  endtask

  task automatic sclk_half(input int ch, input int n_exp);
    int n;
    logic s;
    n = 0;
    @(negedge mclk);
    s = sclk_out[ch];
    while (sclk_out[ch] === s && n < 200) begin
      @(negedge mclk);
      n++;
    end
    s = sclk_out[ch];
    n = 0;
    while (sclk_out[ch] === s && n < 200) begin
      @(negedge mclk);
      n++;
    end
    chk(n, n_exp);
  endtask

  initial begin
    #200000;
    err_count++;
    summarize();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    arst_n = 1'b0;
    ce = 1'b1;
    tap_idx = 7'h00;
    err_count = 0;
    checks_done = 0;
    void'($urandom(23444));
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    arst_n = 1'b1;
    repeat (4) @(negedge mclk);
    chk(coef_offset, 32'h0);
    for (int c = 0; c < 4; c++) begin
      off_e[c] = 8'($urandom);
      wr(8'(c + 1), OFS_COEF_OFFSET, off_e[c], 1);
    end
    chk(coef_offset, off_e);
    for (int c = 0; c < 4; c++) begin
      rd_reg(8'(c + 1), OFS_COEF_OFFSET, off_e[c], 1);
    end
    $display("test offsets done");
    for (int f = 0; f < 4; f++) begin
      v = $urandom;
      v[5:4] = FORMAT_FIR;
      wr(8'h01, OFS_MODE_ONE, v, 1);
      chk(tap_ratio_m1[0], v[3:0]);
      chk(input_format[0], FORMAT_FIR);
    end
    $display("test mode one done");
    for (int c = 0; c < 4; c++) begin
      v = {24'h0, c[1:0], 1'b0, 5'($urandom)};
      wr(8'h02, OFS_MODE_TWO, v, 1);
      chk(sclk_divider[1], v[4:0]);
      chk(coarse_scale[1], v[7:6]);
      rd_reg(8'h02, OFS_MODE_TWO, v, 1);
    end
    sclk_half(1, v[4:0] + 1);
    $display("test mode two done");
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 32'h85 : (i == 1) ? 32'h7f : 32'h20;
      wr(8'h01, OFS_TAP_COUNT, v, 1);
      chk(tap_count_m1[0], (i == 0) ? 7'h7f : v[6:0]);
    end
    $display("test tap count done");
    k = 7'($urandom_range(0, 31));
    v = $urandom;
    wr(8'h03, 8'h20 + k, v, 4);
    host_port_model_inst.put(3'h7, 8'h03);
    host_port_model_inst.put(3'h6, 8'h20 + k);
    host_port_model_inst.put(3'h1, ~v[15:8]);
    rd_reg(8'h03, 8'h20 + k, {16'h0, v[15:0]}, 4);
    k = 7'($urandom);
    w = $urandom;
    wr(8'h03, 8'h80 + k, w, 2);
    rd_reg(8'h03, 8'h80 + k, {16'h0, w[15:0]}, 2);
    off_e[2] = 8'($urandom);
    wr(8'h03, OFS_COEF_OFFSET, off_e[2], 1);
    @(negedge mclk);
    tap_idx = k - off_e[2][6:0];
    repeat (3) @(negedge mclk);
    chk(coef_out[2], w[15:0]);
    $display("test memories done");
    wr(8'h05, OFS_COEF_OFFSET, 32'hff, 1);
    wr(8'h01, 8'h0e, 32'hffff, 2);
    wr(8'h01, 8'h50, 32'hffff, 2);
    chk(coef_offset, off_e);
    chk(tap_count_m1[0], 7'h20);
    rd_reg(8'h05, OFS_COEF_OFFSET, 32'h0, 1);
    rd_reg(8'h01, 8'h0e, 32'h0, 1);
    @(negedge mclk);
    ce = 1'b0;
    host_port_model_inst.wr_reg(8'h04, OFS_COEF_OFFSET, 32'h5a, 1);
    ce = 1'b1;
    wr(8'h04, OFS_TAP_COUNT, 32'h11, 1);
    chk(coef_offset, off_e);
    chk(tap_count_m1[3], 7'h11);
    $display("test refusals done");
    v = {24'h0, 2'h3, 1'b0, 5'h02};
    host_port_model_inst.deint(v[7:0]);
    repeat (2) @(negedge mclk);
    chk(sclk_divider, {4{v[4:0]}});
    chk(coarse_scale, {4{v[7:6]}});
    sclk_half(3, 3);
    $display("test deinterleave done");
    @(negedge mclk);
    arst_n = 1'b0;
    @(negedge mclk);
    chk(coef_offset, 32'h0);
    chk(sclk_divider, 32'h0);
    chk(tap_count_m1, 32'h0);
    chk(host_rdata, 32'h0);
    arst_n = 1'b1;
    repeat (4) @(negedge mclk);
    wr(8'h04, OFS_MODE_TWO, 32'h01, 1);
    chk(sclk_divider[3], 5'h01);
    $display("test reset done");
    chk(exp_q.size(), 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
